// [hw/ioscf_top.sv]
// Internal oscillator frequency selector with Wishbone control registers.
// What this block does
// - Mux postscaled high, mid, low oscillators.
// - Offer twelve frequencies, 32 MHz via PLL.
// - Reset loads frequency select with 0111.
// - Same-source switches faster than source changes.
// - Code 1110 with PLL gives 32 MHz.
// - PLL enabled by software or configuration.
// - Configuration lock keeps PLL on, ignores software.
// - PLL unused when system clock select 1x.
`timescale 1ns/1ns
module ioscf_top (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration word bits.
    input wire logic [2:0] config_osc_select_i,
    input wire logic config_pll_lock_on_i,
    // Oscillator ticks.
    input wire logic hf_tick_i,
    input wire logic mf_tick_i,
    input wire logic lf_tick_i,
    input wire logic pll_tick_i,
    // Clock outputs.
    output logic sys_clk_o,
    output logic pll_en_o,
    output logic sys_internal_o,
    output logic switch_busy_o
);
    typedef enum logic [1:0] {
        IOSCF_RUN,
        IOSCF_PARK,
        IOSCF_SETTLE
    } ioscf_state_t;

    ioscf_state_t state_q;
    logic [1:0] system_clock_select_q;
    logic [3:0] internal_freq_select_q;
    logic soft_pll_enable_q;
    ioscf_pkg::ioscf_sel_t act_q;
    ioscf_pkg::ioscf_sel_t tgt;
    logic [3:0] settle_q;
    logic pll_on;
    logic pll_apply;
    logic wb_req;
    logic wr_ctrl;
    logic div_clk;
    logic div_run;
    logic div_restart;
    logic act_tick;
    logic tgt_tick;
    logic [31:0] rd_data;

    function automatic logic src_tick(input ioscf_pkg::ioscf_src_t s,
            input logic hf, input logic mf, input logic lf, input logic pl);
        logic t;
        t = 1'b0;
        case (s)
            ioscf_pkg::IOSCF_SRC_LF: t = lf;
            ioscf_pkg::IOSCF_SRC_MF: t = mf;
            ioscf_pkg::IOSCF_SRC_HF: t = hf;
            default: t = pl;
        endcase
        return t;
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0]
        && wb_adr_i == ioscf_pkg::IOSCF_CTRL_OFS;

    // Software writes the control fields; reset restores the default code.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_freq_select_q <= ioscf_pkg::IOSCF_FREQ_RST;
            system_clock_select_q <= ioscf_pkg::IOSCF_SYSSEL_RST;
            soft_pll_enable_q <= ioscf_pkg::IOSCF_SPLL_RST;
        end else if (wr_ctrl) begin
            internal_freq_select_q <=
                wb_dat_i[ioscf_pkg::IOSCF_FREQ_POS +: 4];
            system_clock_select_q <=
                wb_dat_i[ioscf_pkg::IOSCF_SYSSEL_POS +: 2];
            soft_pll_enable_q <= wb_dat_i[ioscf_pkg::IOSCF_SPLL_POS];
        end
    end

    // The configuration lock overrides the software enable.
    assign pll_on = config_pll_lock_on_i | soft_pll_enable_q;
    // The PLL joins the path only with the full 32 MHz setup in place.
    assign pll_apply = pll_on
        && system_clock_select_q ==
            ioscf_pkg::IOSCF_SYSSEL_CFG
        && config_osc_select_i == ioscf_pkg::IOSCF_CFG_OSCBLK
        && internal_freq_select_q == ioscf_pkg::IOSCF_FREQ_PLL;

    // Code to source and postscaler; some frequencies repeat on two sources.
    always_comb begin
        tgt.code = internal_freq_select_q;
        tgt.src = ioscf_pkg::IOSCF_SRC_HF;
        tgt.div_log2 = 4'h0;
        case (internal_freq_select_q)
            4'h0, 4'h1: tgt.src = ioscf_pkg::IOSCF_SRC_LF;
            4'h2: begin
                tgt.src = ioscf_pkg::IOSCF_SRC_MF;
                tgt.div_log2 = 4'h4;
            end
            4'h3: tgt.div_log2 = 4'h9;
            4'h4: tgt.div_log2 = 4'h8;
            4'h5: tgt.div_log2 = 4'h7;
            4'h6: tgt.div_log2 = 4'h6;
            4'h7: tgt.src = ioscf_pkg::IOSCF_SRC_MF;
            4'h8: begin
                tgt.src = ioscf_pkg::IOSCF_SRC_MF;
                tgt.div_log2 = 4'h2;
            end
            4'h9: begin
                tgt.src = ioscf_pkg::IOSCF_SRC_MF;
                tgt.div_log2 = 4'h1;
            end
            4'hA: begin
                tgt.src = ioscf_pkg::IOSCF_SRC_MF;
                tgt.div_log2 = 4'h3;
            end
            4'hB: tgt.div_log2 = 4'h4;
            4'hC: tgt.div_log2 = 4'h3;
            4'hD: tgt.div_log2 = 4'h2;
            4'hE: tgt.div_log2 = 4'h1;
            default: tgt.div_log2 = 4'h0;
        endcase
        if (pll_apply) begin
            tgt.src = ioscf_pkg::IOSCF_SRC_PLL;
            tgt.div_log2 = 4'h0;
        end
    end

    assign act_tick = src_tick(act_q.src, hf_tick_i, mf_tick_i, lf_tick_i,
        pll_tick_i);
    assign tgt_tick = src_tick(tgt.src, hf_tick_i, mf_tick_i, lf_tick_i,
        pll_tick_i);

    // The divider keeps running while parking until its output is low.
    assign div_run = (state_q == IOSCF_RUN) ||
        (state_q == IOSCF_PARK && div_clk);
    assign div_restart = (state_q == IOSCF_PARK && !div_clk &&
        tgt.src == act_q.src) || (state_q == IOSCF_SETTLE &&
        settle_q == ioscf_pkg::IOSCF_SETTLE_TICKS);

    // Switch sequencer: park low, settle on a new source, then load.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= IOSCF_RUN;
            act_q.src <= ioscf_pkg::IOSCF_SRC_MF;
            act_q.div_log2 <= 4'h0;
            act_q.code <= ioscf_pkg::IOSCF_FREQ_RST;
        end else begin
            case (state_q)
                IOSCF_RUN: begin
                    if (tgt != act_q) begin
                        state_q <= IOSCF_PARK;
                    end
                end
                IOSCF_PARK: begin
                    if (!div_clk) begin
                        if (tgt.src == act_q.src) begin
                            act_q <= tgt;
                            state_q <= IOSCF_RUN;
                        end else begin
                            state_q <= IOSCF_SETTLE;
                        end
                    end
                end
                IOSCF_SETTLE: begin
                    if (settle_q == ioscf_pkg::IOSCF_SETTLE_TICKS) begin
                        act_q <= tgt;
                        state_q <= IOSCF_RUN;
                    end else if (tgt.src == act_q.src) begin
                        state_q <= IOSCF_PARK;
                    end
                end
                default: state_q <= IOSCF_RUN;
            endcase
        end
    end

    // Counts ticks of the incoming source before it takes over.
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != IOSCF_SETTLE) begin
            settle_q <= 4'h0;
        end else if (tgt_tick &&
                settle_q != ioscf_pkg::IOSCF_SETTLE_TICKS) begin
            settle_q <= 4'(settle_q + 4'h1);
        end
    end

    ioscf_postdiv #(
        .CNT_W(10)
    ) u_postdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(act_tick),
        .run_i(div_run),
        .restart_i(div_restart),
        .div_log2_i(act_q.div_log2),
        .clk_o(div_clk)
    );

    assign sys_clk_o = div_clk;

    // Status flags and the internal-source indication.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_en_o <= 1'b0;
            sys_internal_o <= 1'b0;
            switch_busy_o <= 1'b0;
        end else begin
            pll_en_o <= pll_on;
            sys_internal_o <= system_clock_select_q[1] ||
                (system_clock_select_q == ioscf_pkg::IOSCF_SYSSEL_CFG &&
                config_osc_select_i == ioscf_pkg::IOSCF_CFG_OSCBLK);
            switch_busy_o <= state_q != IOSCF_RUN || tgt != act_q;
        end
    end

    always_comb begin
        rd_data = 32'h0;
        if (wb_adr_i == ioscf_pkg::IOSCF_CTRL_OFS) begin
            rd_data[ioscf_pkg::IOSCF_SYSSEL_POS +: 2] = system_clock_select_q;
            rd_data[ioscf_pkg::IOSCF_FREQ_POS +: 4] = internal_freq_select_q;
            rd_data[ioscf_pkg::IOSCF_SPLL_POS] = soft_pll_enable_q;
        end else if (wb_adr_i == ioscf_pkg::IOSCF_STAT_OFS) begin
            rd_data[ioscf_pkg::IOSCF_ST_SRC_POS +: 2] = act_q.src;
            rd_data[ioscf_pkg::IOSCF_ST_CODE_POS +: 4] = act_q.code;
            rd_data[ioscf_pkg::IOSCF_ST_PLL_POS] =
                act_q.src == ioscf_pkg::IOSCF_SRC_PLL;
            rd_data[ioscf_pkg::IOSCF_ST_BUSY_POS] = state_q != IOSCF_RUN;
            rd_data[ioscf_pkg::IOSCF_ST_PLLON_POS] = pll_on;
        end
    end

    // Single-wait-state Wishbone answer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h0;
        end
    end

    a_reset_default: assert property (@(posedge clk_i)
        $fell(rst_i) |-> internal_freq_select_q == 4'h7 &&
        act_q.src == ioscf_pkg::IOSCF_SRC_MF)
        else $error("Frequency select not at default after reset.");

    a_pll_enable_or: assert property (@(posedge clk_i) disable iff (rst_i)
        (config_pll_lock_on_i || soft_pll_enable_q) |=> pll_en_o)
        else $error("PLL not enabled by its sources.");

    a_pll_lock_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!config_pll_lock_on_i && !soft_pll_enable_q) |=> !pll_en_o)
        else $error("PLL enabled without a source.");

    a_pll_path_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        tgt.src == ioscf_pkg::IOSCF_SRC_PLL |->
        system_clock_select_q == 2'h0 && config_osc_select_i == 3'h4 &&
        internal_freq_select_q == 4'hE)
        else $error("PLL chosen without the full setup.");

    a_switch_low_clk: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(act_q) |-> !div_clk && $past(!div_clk))
        else $error("Mux changed while clock was high.");

    a_same_src_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == IOSCF_PARK && !div_clk && tgt.src == act_q.src
        |=> state_q == IOSCF_RUN && act_q == $past(tgt))
        else $error("Same-source switch not immediate.");

    a_settle_ticks: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(act_q.src) |-> $past(state_q) == IOSCF_SETTLE &&
        $past(settle_q) == ioscf_pkg::IOSCF_SETTLE_TICKS)
        else $error("Source switched before settling.");

    a_lf_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_freq_select_q[3:1] == 3'h0 |->
        tgt.src == ioscf_pkg::IOSCF_SRC_LF && tgt.div_log2 == 4'h0)
        else $error("Low codes not on the low oscillator.");

    a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone ack not a single pulse.");
endmodule

// [hw/ioscf_pkg.sv]
// Shared constants and types of the internal oscillator frequency selector.
package ioscf_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [3:0] IOSCF_CTRL_OFS = 4'h0;
    localparam logic [3:0] IOSCF_STAT_OFS = 4'h4;
    // Control register field positions.
    localparam int IOSCF_SYSSEL_POS = 0;
    localparam int IOSCF_FREQ_POS = 3;
    localparam int IOSCF_SPLL_POS = 7;
    // Status register field positions.
    localparam int IOSCF_ST_SRC_POS = 0;
    localparam int IOSCF_ST_CODE_POS = 2;
    localparam int IOSCF_ST_PLL_POS = 6;
    localparam int IOSCF_ST_BUSY_POS = 7;
    localparam int IOSCF_ST_PLLON_POS = 8;
    // Reset values.
    localparam logic [3:0] IOSCF_FREQ_RST = 4'h7;
    localparam logic [1:0] IOSCF_SYSSEL_RST = 2'h0;
    localparam logic IOSCF_SPLL_RST = 1'b0;
    // Codes that matter to the PLL path.
    localparam logic [3:0] IOSCF_FREQ_PLL = 4'hE;
    localparam logic [2:0] IOSCF_CFG_OSCBLK = 3'h4;
    localparam logic [1:0] IOSCF_SYSSEL_CFG = 2'h0;
    // Source ticks to wait when the mux changes oscillator.
    localparam logic [3:0] IOSCF_SETTLE_TICKS = 4'h4;

    typedef enum logic [1:0] {
        IOSCF_SRC_LF,
        IOSCF_SRC_MF,
        IOSCF_SRC_HF,
        IOSCF_SRC_PLL
    } ioscf_src_t;

    typedef struct packed {
        ioscf_src_t src;
        logic [3:0] div_log2;
        logic [3:0] code;
    } ioscf_sel_t;
endpackage

// [hw/ioscf_postdiv.sv]
// Postscaler that turns source ticks into a glitch-free clock level.
`timescale 1ns/1ns
module ioscf_postdiv #(
    parameter int CNT_W = 10
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [3:0] div_log2_i,
    // Divided clock.
    output logic clk_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;

    assign limit = CNT_W'((CNT_W'(1) << div_log2_i) - CNT_W'(1));

    // The counter restarts only while the output is parked low.
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            cnt_q <= '0;
        end else if (run_i && tick_i) begin
            cnt_q <= (cnt_q >= limit) ? '0 : CNT_W'(cnt_q + CNT_W'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_o <= 1'b0;
        end else if (run_i && tick_i && cnt_q >= limit) begin
            clk_o <= ~clk_o;
        end
    end
endmodule

// [dv/internal_osc_freq_select_tb_top.sv]
// Self-checking testbench of the internal oscillator frequency selector.
`timescale 1ns/1ns
module internal_osc_freq_select_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] config_osc_select_i = 3'h4;
    logic config_pll_lock_on_i = 1'b0;
    logic hf_tick_i = 1'b0;
    logic mf_tick_i = 1'b0;
    logic lf_tick_i = 1'b0;
    logic pll_tick_i = 1'b0;
    logic sys_clk_o;
    logic pll_en_o;
    logic sys_internal_o;
    logic switch_busy_o;
    int bad_count = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int tog_cnt = 0;
    logic meas_on = 1'b0;
    logic clk_prev = 1'b0;
    logic [31:0] rnd = 32'h0000DF00;
    logic [31:0] rd;
    logic [31:0] last;
    int t_same;
    int t_diff;
    int rc;
    int rp;
    int rs;
    // Source and postscaler exponent of every frequency code.
    int src_tab [$] = {0, 0, 1, 2, 2, 2, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2};
    int div_tab [$] = {0, 0, 4, 9, 8, 7, 6, 0, 2, 1, 3, 4, 3, 2, 1, 0};
    localparam logic [3:0] CTRL = ioscf_pkg::IOSCF_CTRL_OFS;
    localparam logic [3:0] STAT = ioscf_pkg::IOSCF_STAT_OFS;

    ioscf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .config_osc_select_i(config_osc_select_i),
        .config_pll_lock_on_i(config_pll_lock_on_i), .hf_tick_i(hf_tick_i),
        .mf_tick_i(mf_tick_i), .lf_tick_i(lf_tick_i),
        .pll_tick_i(pll_tick_i), .sys_clk_o(sys_clk_o), .pll_en_o(pll_en_o),
        .sys_internal_o(sys_internal_o), .switch_busy_o(switch_busy_o));

    always #25 clk_i = ~clk_i;

    // Oscillator ticks, toggle counting and the hang limit.
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        hf_tick_i <= 1'b1;
        pll_tick_i <= 1'b1;
        mf_tick_i <= cyc_cnt[0];
        lf_tick_i <= (cyc_cnt[1:0] == 2'h0);
        clk_prev <= sys_clk_o;
        if (meas_on && sys_clk_o !== clk_prev) begin
            tog_cnt <= tog_cnt + 1;
        end
        if (cyc_cnt == 40000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] adr,
            input logic [3:0] sel, input logic [31:0] dat,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask

    task automatic rchk(input logic [3:0] adr, input logic [31:0] mask,
            input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 4'hF, 32'h0, q);
        chk(q & mask, exp & mask);
    endtask

    task automatic settle(output int t);
        t = 0;
        repeat (3) @(posedge clk_i);
        while (switch_busy_o !== 1'b0 && t < 3000) begin
            @(posedge clk_i);
            t = t + 1;
        end
        if (t >= 3000) chk(32'h1, 32'h0);
    endtask

    function automatic logic [31:0] ctl(int s, int c, int p);
        return 32'(s) | (32'(c) << ioscf_pkg::IOSCF_FREQ_POS)
            | (32'(p) << ioscf_pkg::IOSCF_SPLL_POS);
    endfunction

    function automatic logic [31:0] stat(int s, int c, int pp, int pe);
        return 32'(s) | (32'(c) << ioscf_pkg::IOSCF_ST_CODE_POS)
            | (32'(pp) << ioscf_pkg::IOSCF_ST_PLL_POS)
            | (32'(pe) << ioscf_pkg::IOSCF_ST_PLLON_POS);
    endfunction

    // Xorshift step that feeds random control words.
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Counts output toggles over 64 source ticks.
    task automatic meas(input int s, input int d);
        int n;
        int t0;
        n = 64 >> d;
        @(posedge clk_i);
        t0 = tog_cnt;
        meas_on <= 1'b1;
        repeat (64 * (s == 0 ? 4 : (s == 1 ? 2 : 1))) @(posedge clk_i);
        meas_on <= 1'b0;
        @(posedge clk_i);
        t0 = tog_cnt - t0;
        chk(32'(t0 >= n - 1 && t0 <= n + 1), 32'h1);
    endtask

    task automatic wset(input logic [31:0] v, output int t);
        wb(1'b1, CTRL, 4'h1, v, rd);
        settle(t);
    endtask

    task automatic report_and_stop();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(CTRL, 32'hFB, 32'h38);
        rchk(STAT, 32'h1FF, stat(1, 7, 0, 0));
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, CTRL, 4'h1, ctl(0, c, 0), rd);
            @(posedge clk_i);
            chk(32'(switch_busy_o), 32'h1);
            settle(t_same);
            rchk(STAT, 32'h1FF, stat(src_tab[c], c, 0, 0));
            if (div_tab[c] <= 4) meas(src_tab[c], div_tab[c]);
        end
        wset(ctl(0, 14, 0), t_same);
        wset(ctl(0, 7, 0), t_diff);
        chk(32'(t_same < t_diff), 32'h1);
        config_pll_lock_on_i <= 1'b1;
        wset(ctl(0, 14, 0), t_same);
        rchk(STAT, 32'h1FF, stat(3, 14, 1, 1));
        chk(32'(pll_en_o), 32'h1);
        meas(3, 0);
        wset(ctl(2, 14, 0), t_same);
        rchk(STAT, 32'h1FF, stat(2, 14, 0, 1));
        chk(32'(sys_internal_o), 32'h1);
        wset(ctl(1, 14, 0), t_same);
        rchk(STAT, 32'h1FF, stat(2, 14, 0, 1));
        chk(32'(sys_internal_o), 32'h0);
        config_osc_select_i <= 3'h2;
        wset(ctl(0, 14, 0), t_same);
        rchk(STAT, 32'h1FF, stat(2, 14, 0, 1));
        chk(32'(sys_internal_o), 32'h0);
        config_osc_select_i <= 3'h4;
        config_pll_lock_on_i <= 1'b0;
        settle(t_same);
        chk(32'(sys_internal_o), 32'h1);
        chk(32'(pll_en_o), 32'h0);
        rchk(STAT, 32'h1FF, stat(2, 14, 0, 0));
        wset(ctl(0, 14, 1), t_same);
        chk(32'(pll_en_o), 32'h1);
        rchk(STAT, 32'h1FF, stat(3, 14, 1, 1));
        repeat (4) begin
            rnd = xs(rnd);
            wb(1'b1, CTRL, 4'hF, rnd, rd);
            settle(t_same);
            rchk(CTRL, 32'hFB, rnd);
            rc = int'(rnd[6:3]);
            rp = int'(rnd[7] && rnd[1:0] == 2'h0 && rc == 14);
            rs = rp != 0 ? 3 : src_tab[rc];
            rchk(STAT, 32'h1FF, stat(rs, rc, rp, int'(rnd[7])));
        end
        last = rnd;
        wb(1'b1, 4'h8, 4'hF, 32'hFF, rd);
        rchk(4'h8, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, CTRL, 4'hE, ctl(0, 5, 0), rd);
        wb(1'b1, STAT, 4'hF, 32'hFFFFFFFF, rd);
        rchk(CTRL, 32'hFB, last);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(CTRL, 32'hFB, 32'h38);
        rchk(STAT, 32'h1FF, stat(1, 7, 0, 0));
        chk(32'(pll_en_o), 32'h0);
        report_and_stop();
    end
endmodule
